// [dfi_regs.svh]
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 8-bit register port, byte-wide offsets as printed
// Notes: included by the package and the top module
`ifndef DFI_REGS_SVH
`define DFI_REGS_SVH
`define DFI_ADDR_IRQ_EN_A 8'h03
`define DFI_ADDR_IRQ_EN_B 8'h04
`define DFI_ADDR_STATUS 8'h06
`define DFI_ADDR_FRAME_CFG 8'h22
`define DFI_ADDR_LEVEL_REQ 8'h23
`define DFI_ADDR_LEVEL_RB 8'h24
`define DFI_ADDR_DROOP_CFG 8'h27
`define DFI_ADDR_INTERP_CFG 8'h28
`define DFI_ADDR_GAIN 8'h3C
`define DFI_ADDR_OFFSET 8'h3D
`define DFI_BIT_UNDERFLOW 2
`define DFI_BIT_OVERFLOW 1
`define DFI_BIT_CONT_EN 2
`define DFI_BIT_DROOP_EN 7
`define DFI_BIT_INTERP_2X 7
`define DFI_FRAME_ARM 2'h2
`define DFI_LEVEL_REQ_RST 8'h40
`define DFI_GAIN_RST 8'h40
`define DFI_FIFO_DEPTH 8
`define DFI_HB_TAPS 55
`define DFI_IS_TAPS 7
`endif

// [dfi_pkg.sv]
// Purpose: shared types for the interpolating datapath
// Assumes: constants come from dfi_regs.svh
// Notes: types only
`include "dfi_regs.svh"
package dfi_pkg;
    typedef logic signed [15:0] dfi_sample_t;
    typedef enum logic [1:0] {DFI_IDLE, DFI_ARMED, DFI_DONE} dfi_frame_st_t;
endpackage

// [dfi_stage_if.sv]
// Purpose: sample carrier between datapath stages
// Assumes: one converter clock
// Notes: valid marks a new sample
`timescale 1ns/1ps
interface dfi_stage_if;
    import dfi_pkg::*;
    dfi_sample_t data;
    logic valid;
    logic enable;
    modport src (output data, output valid, output enable);
    modport dst (input data, input valid, input enable);
endinterface

// [dfi_halfband.sv]
// Purpose: 2x half-band interpolator, bypassed in 1x
// Assumes: input valid at most every other cycle in 2x
// Notes: polyphase; even phase is delayed centre tap
`timescale 1ns/1ps
module dfi_halfband
    import dfi_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    dfi_stage_if.dst up,
    dfi_stage_if.src dn
);
    localparam int NH = 28;
    // odd taps H(1)..H(27); H(28)=32768 centre
    localparam int signed COEF [14] = '{-4, 13, -32, 69, -134, 239, -401, 642,
        -994, 1512, -2307, 3665, -6638, 20754};
    dfi_sample_t hist_q [NH];
    dfi_sample_t hist_d [NH];
    dfi_sample_t out_d, out_q;
    logic vld_d, vld_q, ph_d, ph_q;
    logic signed [39:0] acc;
    logic signed [39:0] rnd;
    // next-value logic; centre sample output then odd phase
    always_comb
    begin
        hist_d = hist_q;
        out_d = out_q;
        vld_d = 1'b0;
        ph_d = 1'b0;
        acc = '0;
        for (int k = 0; k < 14; k++)
        begin
            acc = acc + COEF[k] * (40'(hist_q[k]) + 40'(hist_q[NH-1-k]));
        end
        rnd = (acc + 40'sh8000) >>> 16;
        if (!up.enable)
        begin
            out_d = up.data;
            vld_d = up.valid;
        end
        else if (up.valid)
        begin
            for (int i = NH - 1; i > 0; i--)
            begin
                hist_d[i] = hist_q[i-1];
            end
            hist_d[0] = up.data;
            // centre tap 32768/65536 = half, taken from the middle
            out_d = dfi_sample_t'((40'(hist_q[13]) + 40'sd1) >>> 1);
            vld_d = 1'b1;
            ph_d = 1'b1;
        end
        else if (ph_q)
        begin
            // rescale and saturate the filtered phase
            if (rnd > 40'sd32767)
                out_d = 16'sh7FFF;
            else if (rnd < -40'sd32768)
                out_d = 16'sh8000;
            else
                out_d = dfi_sample_t'(rnd[15:0]);
            vld_d = 1'b1;
        end
    end
    // registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < NH; i++)
                hist_q[i] <= '0;
            out_q <= '0;
            vld_q <= 1'b0;
            ph_q <= 1'b0;
        end
        else
        begin
            hist_q <= hist_d;
            out_q <= out_d;
            vld_q <= vld_d;
            ph_q <= ph_d;
        end
    end
    assign dn.data = out_q;
    assign dn.valid = vld_q;
    assign dn.enable = up.enable;
endmodule

// [dfi_droop.sv]
// Purpose: seven-tap inverse sinc compensator with bypass
// Assumes: runs once per output sample
// Notes: coefficients -1,4,-16,192 symmetric, result over 256
`timescale 1ns/1ps
module dfi_droop
    import dfi_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    dfi_stage_if.dst up,
    dfi_stage_if.src dn
);
    dfi_sample_t tap_q [7];
    dfi_sample_t tap_d [7];
    dfi_sample_t out_d, out_q;
    logic vld_q;
    logic signed [31:0] acc;
    logic signed [31:0] rnd;
    // next values; filter kept running so bypass switch is glitch-free
    always_comb
    begin
        tap_d = tap_q;
        acc = -(32'(tap_q[0]) + 32'(tap_q[6])) + 32'sd4 * (32'(tap_q[1]) + 32'(tap_q[5]))
            - 32'sd16 * (32'(tap_q[2]) + 32'(tap_q[4])) + 32'sd192 * 32'(tap_q[3]);
        rnd = (acc + 32'sd128) >>> 8;
        out_d = out_q;
        if (up.valid)
        begin
            for (int i = 6; i > 0; i--)
                tap_d[i] = tap_q[i-1];
            tap_d[0] = up.data;
            if (!up.enable)
                out_d = up.data;
            else if (rnd > 32'sd32767)
                out_d = 16'sh7FFF;
            else if (rnd < -32'sd32768)
                out_d = 16'sh8000;
            else
                out_d = dfi_sample_t'(rnd[15:0]);
        end
    end
    // registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < 7; i++)
                tap_q[i] <= '0;
            out_q <= '0;
            vld_q <= 1'b0;
        end
        else
        begin
            tap_q <= tap_d;
            out_q <= out_d;
            vld_q <= up.valid;
        end
    end
    assign dn.data = out_q;
    assign dn.valid = vld_q;
    assign dn.enable = up.enable;
endmodule

// [dfi_top.sv]
// Purpose: frame-reset FIFO crossing plus interpolating datapath
// Assumes: data_clock_in words already captured; frame pin synchronised here
// Notes: registers reached over a simple 8-bit address/data port
`timescale 1ns/1ps
`include "dfi_regs.svh"
// Behaviour
// - frame marks start of assembled byte stream in byte mode
// - continuous mode resets FIFO on every valid frame pulse
// - one-shot mode resets only on first valid pulse after arming write
// - one-shot is the reset default
// - writing 10 to mode field arms frame reset
// - bit 2 picks continuous when set, one-shot when clear
// - level after reset within one converter cycle of request
// - level readback shows live depth in request format
// - status bits flag underflow and overflow
// - enabled status bits latch and drive interrupt outputs
// - 1x or 2x interpolation modes
// - 55-tap half-band with listed odd taps and centre
// - seven-tap inverse sinc -1 4 -16 192
// - inverse sinc off after reset, bit 7 enables it
// - datapath is half-band, inverse sinc, gain and offset
// - latency depends on enabled functions
// - buffer two channels, 16-bit, eight deep
// - level request integer bits 6:4, fraction bits 2:0
// - pointers advance once per input sample
module dfi_top
    import dfi_pkg::*;
#(
    parameter int DEPTH = `DFI_FIFO_DEPTH,
    parameter int FRAME_MIN = 2
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic frame_in,
    input wire logic word_valid_in,
    input wire logic [15:0] word_a_in,
    input wire logic [15:0] word_b_in,
    input wire logic byte_mode_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic stream_start_out,
    output logic [15:0] sample_a_out,
    output logic [15:0] sample_b_out,
    output logic sample_valid_out,
    output logic irq_out_a,
    output logic irq_out_b
);
    localparam int AW = $clog2(DEPTH);
    dfi_sample_t mem_a [DEPTH];
    dfi_sample_t mem_b [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic fr_s1_q, fr_s2_q, fr_s3_q;
    logic [2:0] frcnt_q, frcnt_d;
    logic frame_valid;
    dfi_frame_st_t fst_q, fst_d;
    logic [1:0] mode_q, mode_d;
    logic cont_q, cont_d, droop_q, droop_d, i2x_q, i2x_d;
    logic [7:0] lvl_q, lvl_d, en_a_q, en_a_d, en_b_q, en_b_d, gain_q, gain_d, ofs_q, ofs_d;
    logic [7:0] rd_d;
    logic ph_q, ph_d, tick;
    logic uf_q, uf_d, of_q, of_d, lat_uf_q, lat_uf_d, lat_of_q, lat_of_d;
    logic [7:0] rb_q, rb_d;
    logic do_reset;
    logic [AW-1:0] depth_now;
    logic ss_q;
    logic [15:0] oa_d, ob_d;
    logic ov_d;
    logic signed [31:0] ga, gb;
    dfi_stage_if hb_in_a (), hb_out_a (), is_out_a ();
    dfi_stage_if hb_in_b (), hb_out_b (), is_out_b ();
    dfi_stage_if is_in_a (), is_in_b ();

    // frame synchroniser; only stage two onward feeds logic
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            fr_s1_q <= 1'b0;
            fr_s2_q <= 1'b0;
            fr_s3_q <= 1'b0;
            ss_q <= 1'b0;
        end
        else
        begin
            fr_s1_q <= frame_in;
            fr_s2_q <= fr_s1_q;
            fr_s3_q <= fr_s2_q;
            ss_q <= fr_s2_q & ~fr_s3_q;
        end
    end

    // pulse length qualifier; short byte markers do not reset
    always_comb
    begin
        frcnt_d = fr_s2_q ? ((frcnt_q == 3'h7) ? frcnt_q : frcnt_q + 3'h1) : 3'h0;
        frame_valid = fr_s2_q && (frcnt_q == 3'(byte_mode_in ? 2 * FRAME_MIN - 1 : FRAME_MIN - 1));
    end

    // frame reset arming state
    always_comb
    begin
        fst_d = fst_q;
        do_reset = 1'b0;
        unique case (fst_q)
            DFI_IDLE:
            begin
                if (reg_wr_in && reg_addr_in == `DFI_ADDR_FRAME_CFG
                    && reg_wdata_in[1:0] == `DFI_FRAME_ARM)
                    fst_d = DFI_ARMED;
            end
            DFI_ARMED:
            begin
                if (frame_valid)
                begin
                    do_reset = 1'b1;
                    fst_d = cont_q ? DFI_ARMED : DFI_DONE;
                end
                if (mode_q != `DFI_FRAME_ARM)
                    fst_d = DFI_IDLE;
            end
            DFI_DONE:
            begin
                if (reg_wr_in && reg_addr_in == `DFI_ADDR_FRAME_CFG)
                    fst_d = (reg_wdata_in[1:0] == `DFI_FRAME_ARM) ? DFI_ARMED : DFI_IDLE;
            end
        endcase
    end

    // register writes and reads
    always_comb
    begin
        mode_d = mode_q;
        cont_d = cont_q;
        droop_d = droop_q;
        i2x_d = i2x_q;
        lvl_d = lvl_q;
        en_a_d = en_a_q;
        en_b_d = en_b_q;
        gain_d = gain_q;
        ofs_d = ofs_q;
        if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                `DFI_ADDR_FRAME_CFG:
                begin
                    mode_d = reg_wdata_in[1:0];
                    cont_d = reg_wdata_in[`DFI_BIT_CONT_EN];
                end
                `DFI_ADDR_LEVEL_REQ: lvl_d = reg_wdata_in & 8'h77;
                `DFI_ADDR_IRQ_EN_A: en_a_d = reg_wdata_in;
                `DFI_ADDR_IRQ_EN_B: en_b_d = reg_wdata_in;
                `DFI_ADDR_DROOP_CFG: droop_d = reg_wdata_in[`DFI_BIT_DROOP_EN];
                `DFI_ADDR_INTERP_CFG: i2x_d = reg_wdata_in[`DFI_BIT_INTERP_2X];
                `DFI_ADDR_GAIN: gain_d = reg_wdata_in;
                `DFI_ADDR_OFFSET: ofs_d = reg_wdata_in;
                default: ;
            endcase
        end
        rd_d = reg_rdata_out;
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                `DFI_ADDR_FRAME_CFG: rd_d = {5'h00, cont_q, mode_q};
                `DFI_ADDR_LEVEL_REQ: rd_d = lvl_q;
                `DFI_ADDR_LEVEL_RB: rd_d = rb_q;
                `DFI_ADDR_STATUS: rd_d = {5'h00, lat_uf_q | uf_q, lat_of_q | of_q, 1'b0};
                `DFI_ADDR_IRQ_EN_A: rd_d = en_a_q;
                `DFI_ADDR_IRQ_EN_B: rd_d = en_b_q;
                `DFI_ADDR_DROOP_CFG: rd_d = {droop_q, 7'h00};
                `DFI_ADDR_INTERP_CFG: rd_d = {i2x_q, 7'h00};
                `DFI_ADDR_GAIN: rd_d = gain_q;
                `DFI_ADDR_OFFSET: rd_d = ofs_q;
                default: rd_d = 8'h00;
            endcase
        end
    end

    // pointer tick per input sample; reset loads request
    always_comb
    begin
        ph_d = i2x_q ? ~ph_q : 1'b0;
        tick = i2x_q ? ph_q : 1'b1;
        wp_d = (word_valid_in && tick) ? wp_q + AW'(1) : wp_q;
        rp_d = tick ? rp_q + AW'(1) : rp_q;
        if (do_reset)
        begin
            rp_d = '0;
            wp_d = AW'(lvl_q[6:4]);
            ph_d = i2x_q & lvl_q[0];
        end
        depth_now = wp_q - rp_q;
        // live depth, same format as request
        rb_d = {1'b0, 3'(depth_now), 3'h0, i2x_q & ph_q};
        of_d = (depth_now == '0) && word_valid_in && tick && !do_reset;
        uf_d = (depth_now == '0) && !word_valid_in && tick && !do_reset;
        // latch when enabled; clear wins, cleared by enable write
        lat_uf_d = (uf_q & en_a_q[`DFI_BIT_UNDERFLOW]) | (lat_uf_q & en_a_q[`DFI_BIT_UNDERFLOW]);
        lat_of_d = (of_q & en_b_q[`DFI_BIT_OVERFLOW]) | (lat_of_q & en_b_q[`DFI_BIT_OVERFLOW]);
    end

    always_ff @(posedge clk_in)
    begin
        if (word_valid_in && tick)
        begin
            mem_a[wp_q] <= word_a_in;
            mem_b[wp_q] <= word_b_in;
        end
    end

    // buffer feeds half-band then inverse sinc; mode select
    assign hb_in_a.data = mem_a[rp_q];
    assign hb_in_b.data = mem_b[rp_q];
    assign hb_in_a.valid = tick;
    assign hb_in_b.valid = tick;
    assign hb_in_a.enable = i2x_q;
    assign hb_in_b.enable = i2x_q;
    assign is_in_a.data = hb_out_a.data;
    assign is_in_b.data = hb_out_b.data;
    assign is_in_a.valid = hb_out_a.valid;
    assign is_in_b.valid = hb_out_b.valid;
    // droop compensation gated by its enable
    assign is_in_a.enable = droop_q;
    assign is_in_b.enable = droop_q;

    dfi_halfband u_hb_a (.clk_in(clk_in), .rst_n_in(rst_n_in), .up(hb_in_a), .dn(hb_out_a));
    dfi_halfband u_hb_b (.clk_in(clk_in), .rst_n_in(rst_n_in), .up(hb_in_b), .dn(hb_out_b));
    // inverse sinc per channel; adds one register cycle even in bypass
    dfi_droop u_is_a (.clk_in(clk_in), .rst_n_in(rst_n_in), .up(is_in_a), .dn(is_out_a));
    dfi_droop u_is_b (.clk_in(clk_in), .rst_n_in(rst_n_in), .up(is_in_b), .dn(is_out_b));

    // gain (unity at 64) and offset, saturating
    always_comb
    begin
        ga = ((32'(is_out_a.data) * $signed({24'h0, gain_q})) >>> 6) + 32'($signed(ofs_q));
        gb = ((32'(is_out_b.data) * $signed({24'h0, gain_q})) >>> 6) + 32'($signed(ofs_q));
        oa_d = (ga > 32'sd32767) ? 16'h7FFF : (ga < -32'sd32768) ? 16'h8000 : ga[15:0];
        ob_d = (gb > 32'sd32767) ? 16'h7FFF : (gb < -32'sd32768) ? 16'h8000 : gb[15:0];
        ov_d = is_out_a.valid;
    end

    // state registers except synchroniser and buffer; one-shot, droop off at reset
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            frcnt_q <= 3'h0;
            fst_q <= DFI_IDLE;
            mode_q <= 2'h0;
            cont_q <= 1'b0;
            droop_q <= 1'b0;
            i2x_q <= 1'b0;
            lvl_q <= `DFI_LEVEL_REQ_RST;
            en_a_q <= 8'h00;
            en_b_q <= 8'h00;
            gain_q <= `DFI_GAIN_RST;
            ofs_q <= 8'h00;
            reg_rdata_out <= 8'h00;
            wp_q <= '0;
            rp_q <= '0;
            ph_q <= 1'b0;
            rb_q <= 8'h00;
            uf_q <= 1'b0;
            of_q <= 1'b0;
            lat_uf_q <= 1'b0;
            lat_of_q <= 1'b0;
            irq_out_a <= 1'b0;
            irq_out_b <= 1'b0;
            sample_a_out <= 16'h0000;
            sample_b_out <= 16'h0000;
            sample_valid_out <= 1'b0;
        end
        else
        begin
            frcnt_q <= frcnt_d;
            fst_q <= fst_d;
            mode_q <= mode_d;
            cont_q <= cont_d;
            droop_q <= droop_d;
            i2x_q <= i2x_d;
            lvl_q <= lvl_d;
            en_a_q <= en_a_d;
            en_b_q <= en_b_d;
            gain_q <= gain_d;
            ofs_q <= ofs_d;
            reg_rdata_out <= rd_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            ph_q <= ph_d;
            rb_q <= rb_d;
            uf_q <= uf_d;
            of_q <= of_d;
            lat_uf_q <= lat_uf_d;
            lat_of_q <= lat_of_d;
            irq_out_a <= lat_uf_d;
            irq_out_b <= lat_of_d;
            sample_a_out <= oa_d;
            sample_b_out <= ob_d;
            sample_valid_out <= ov_d;
        end
    end
    assign stream_start_out = ss_q;
endmodule

// [dfi_chk_properties.sv]
// Purpose: port-level checks for the frame-reset interpolating datapath
// Assumes: one converter clock, synchronous active-low reset
// Notes: attached by bind from the bench top file
`timescale 1ns/1ps
module dfi_chk
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic frame_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic stream_start_out,
    input wire logic sample_valid_out,
    input wire logic irq_out_a,
    input wire logic irq_out_b
);
    logic seen_a_q;
    logic seen_a_d;
    logic seen_b_q;
    logic seen_b_d;
    // remembers an enabling write; no interrupt can be legal before it
    always_comb
    begin
        seen_a_d = seen_a_q | (reg_wr_in & (reg_addr_in == 8'h03) & reg_wdata_in[2]);
        seen_b_d = seen_b_q | (reg_wr_in & (reg_addr_in == 8'h04) & reg_wdata_in[1]);
    end
    always_ff @(posedge clk_in)
    begin
        seen_a_q <= rst_n_in ? seen_a_d : 1'b0;
        seen_b_q <= rst_n_in ? seen_b_d : 1'b0;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_rd_level;
        reg_rd_in && reg_addr_in == 8'h24;
    endsequence
    sequence s_frame_held;
        $rose(frame_in) ##1 frame_in;
    endsequence
    property p_rd_hold;
        !$past(reg_rd_in) |-> $stable(reg_rdata_out);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
    property p_unmapped;
        reg_rd_in && !(reg_addr_in inside {8'h03, 8'h04, 8'h06, 8'h22, 8'h23, 8'h24, 8'h27,
            8'h28, 8'h3C, 8'h3D}) |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_lvl_fmt;
        s_rd_level |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[3:1] == 3'h0;
    endproperty
    a_lvl_fmt: assert property (p_lvl_fmt) else $error("level readback format");
    property p_stat_fmt;
        reg_rd_in && reg_addr_in == 8'h06 |=> (reg_rdata_out & 8'hF9) == 8'h00;
    endproperty
    a_stat_fmt: assert property (p_stat_fmt) else $error("status stray bits");
    property p_ss_pulse;
        stream_start_out |=> !stream_start_out;
    endproperty
    a_ss_pulse: assert property (p_ss_pulse) else $error("stream start too long");
    property p_ss_cause;
        s_frame_held |-> ##[1:4] stream_start_out;
    endproperty
    a_ss_cause: assert property (p_ss_cause) else $error("frame rise not marked");
    property p_irq_a_gate;
        !seen_a_q |-> !irq_out_a;
    endproperty
    a_irq_a_gate: assert property (p_irq_a_gate) else $error("irq a while never enabled");
    property p_irq_b_gate;
        !seen_b_q |-> !irq_out_b;
    endproperty
    a_irq_b_gate: assert property (p_irq_b_gate) else $error("irq b while never enabled");
    property p_irq_a_clr;
        reg_wr_in && reg_addr_in == 8'h03 && !reg_wdata_in[2] |-> ##2 !irq_out_a;
    endproperty
    a_irq_a_clr: assert property (p_irq_a_clr) else $error("irq a not cleared");
    property p_rst_quiet;
        $rose(rst_n_in) |-> !irq_out_a && !irq_out_b && !stream_start_out && !sample_valid_out
            && reg_rdata_out == 8'h00;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
endmodule

// [dfi_src_model.sv]
// Purpose: behavioural data source beside the block's sample input
// Assumes: words already in the converter clock domain
// Notes: idle word lines carry random values, or the constant on a and its negation on b when const is asked
`timescale 1ns/1ps
module dfi_src_model
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic frame_req_in,
    input wire logic [3:0] frame_len_in,
    input wire logic gap_in,
    input wire logic half_rate_in,
    input wire logic const_in,
    input wire logic [15:0] const_val_in,
    output logic frame_out = 1'b0,
    output logic word_valid_out = 1'b0,
    output logic [15:0] word_a_out = 16'h0000,
    output logic [15:0] word_b_out = 16'h0000
);
    logic [3:0] left;
    logic phase;
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            left <= 4'h0;
            frame_out <= 1'b0;
        end
        else if (frame_req_in)
        begin
            left <= frame_len_in - 4'h1;
            frame_out <= 1'b1;
        end
        else
        begin
            left <= (left != 4'h0) ? left - 4'h1 : 4'h0;
            frame_out <= (left != 4'h0);
        end
    end
    // one word per cycle, or every other cycle when half rate is asked
    always @(posedge clk_in)
    begin
        phase <= rst_n_in ? ~phase : 1'b0;
        word_valid_out <= rst_n_in && !gap_in && (!half_rate_in || phase);
        word_a_out <= const_in ? const_val_in : 16'($urandom);
        word_b_out <= const_in ? -const_val_in : 16'($urandom);
    end
endmodule

// [tb.sv]
// Purpose: self-checking bench for the frame-reset datapath
// Assumes: 200 MHz converter clock, bench inputs moved 1 ns after an edge, model outputs on the edge
// Notes: partner model supplies words and frame pulses
`timescale 1ns/1ps
bind dfi_top dfi_chk dfi_chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .frame_in(frame_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .stream_start_out(stream_start_out), .sample_valid_out(sample_valid_out),
    .irq_out_a(irq_out_a), .irq_out_b(irq_out_b));
module tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic byte_mode_in = 1'b0;
    logic frame_req = 1'b0;
    logic [3:0] frame_len = 4'h2;
    logic gap_on = 1'b0;
    logic half_rate = 1'b0;
    logic const_on = 1'b0;
    logic frame_in, word_valid_in, stream_start_out, sample_valid_out, irq_out_a, irq_out_b;
    logic [15:0] word_a_in, word_b_in, sample_a_out, sample_b_out;
    logic [7:0] reg_rdata_out;
    logic [7:0] rb;
    logic [15:0] rst_tab [9] = '{16'h2200, 16'h2340, 16'h2700, 16'h2800, 16'h3C40, 16'h3D00,
        16'h0300, 16'h0400, 16'h5500};
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    int ss_count = 0;
    always #2.5 clk_in = ~clk_in;
    dfi_top dfi_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .frame_in(frame_in),
        .word_valid_in(word_valid_in), .word_a_in(word_a_in), .word_b_in(word_b_in),
        .byte_mode_in(byte_mode_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .stream_start_out(stream_start_out), .sample_a_out(sample_a_out),
        .sample_b_out(sample_b_out), .sample_valid_out(sample_valid_out),
        .irq_out_a(irq_out_a), .irq_out_b(irq_out_b));
    dfi_src_model dfi_src_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .frame_req_in(frame_req), .frame_len_in(frame_len), .gap_in(gap_on),
        .half_rate_in(half_rate), .const_in(const_on), .const_val_in(16'h0400),
        .frame_out(frame_in), .word_valid_out(word_valid_in), .word_a_out(word_a_in),
        .word_b_out(word_b_in));
    task automatic report_and_stop();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // cycle ceiling well above the few hundred cycles the run needs
    always @(posedge clk_in)
    begin
        cycles++;
        if (stream_start_out === 1'b1)
            ss_count++;
        if (cycles == 20000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // strobe held over one edge, then a quiet cycle so strobes never abut
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        tick();
        reg_wr_in = 1'b0;
        reg_wdata_in = 8'($urandom);
        tick();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        tick();
        reg_rd_in = 1'b0;
        tick();
        d = reg_rdata_out;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t reg got %h want %h", $time, got, exp);
        end
    endtask
    // level in converter cycles: integer part times factor plus fraction
    function automatic int units(input logic [7:0] v, input int f);
        return v[6:4] * f + v[2:0];
    endfunction
    task automatic chk_lvl(input logic [7:0] got, input logic [7:0] req, input int f);
        int d;
        d = units(got, f) - units(req, f);
        checks++;
        if ($isunknown(got) || d > 1 || d < -1)
        begin
            fail_count++;
            $display("BAD %0t level got %h near %h", $time, got, req);
        end
    endtask
    // latency depends on enabled stages, so wait a bounded while for the value
    task automatic chk16(input logic [15:0] ea, input logic [15:0] eb);
        int n;
        n = 0;
        while (!(sample_valid_out === 1'b1 && sample_a_out === ea && sample_b_out === eb)
            && n < 40)
        begin
            tick();
            n++;
        end
        checks++;
        if (n == 40)
        begin
            fail_count++;
            $display("BAD %0t sample got %h %h want %h %h", $time, sample_a_out,
                sample_b_out, ea, eb);
        end
    endtask
    task automatic pulse(input logic [3:0] len);
        frame_req = 1'b1;
        frame_len = len;
        tick();
        frame_req = 1'b0;
        tick(int'(len) + 12);
    endtask
    task automatic gap(input int n);
        gap_on = 1'b1;
        tick(n);
        gap_on = 1'b0;
        tick(2);
    endtask
    initial
    begin
        void'($urandom(32'h6E58));
        tick(8);
        rst_n_in = 1'b1;
        tick();
        for (int i = 0; i < 9; i++)
        begin
            rd(rst_tab[i][15:8], rb);
            chk8(rb, rst_tab[i][7:0]);
        end
        wr(8'h23, 8'h40);
        wr(8'h22, 8'h02);
        pulse(4'h2);
        rd(8'h24, rb);
        chk_lvl(rb, 8'h40, 1);
        gap(2);
        rd(8'h24, rb);
        chk_lvl(rb, 8'h20, 1);
        pulse(4'(2 + $urandom % 3));
        rd(8'h24, rb);
        chk_lvl(rb, 8'h20, 1);
        wr(8'h22, 8'h06);
        rd(8'h22, rb);
        chk8(rb, 8'h06);
        byte_mode_in = 1'b1;
        pulse(4'h4);
        rd(8'h24, rb);
        chk_lvl(rb, 8'h40, 1);
        gap(2);
        pulse(4'h4);
        rd(8'h24, rb);
        chk_lvl(rb, 8'h40, 1);
        byte_mode_in = 1'b0;
        chk8(8'(ss_count), 8'h04);
        const_on = 1'b1;
        chk16(16'h0400, 16'hFC00);
        wr(8'h27, 8'h80);
        chk16(16'h0298, 16'hFD68);
        wr(8'h28, 8'h80);
        half_rate = 1'b1;
        pulse(4'h4);
        tick(80);
        chk16(16'h014C, 16'hFEB4);
        wr(8'h3D, 8'h10);
        chk16(16'h015C, 16'hFEC4);
        half_rate = 1'b0;
        wr(8'h28, 8'h00);
        wr(8'h27, 8'h00);
        pulse(4'h2);
        wr(8'h04, 8'h02);
        gap(4);
        rd(8'h06, rb);
        chk8(rb & 8'h02, 8'h02);
        chk8({7'h00, irq_out_b}, 8'h01);
        wr(8'h04, 8'h00);
        chk8({7'h00, irq_out_b}, 8'h00);
        pulse(4'h2);
        wr(8'h03, 8'h04);
        gap(10);
        rd(8'h06, rb);
        chk8(rb & 8'h04, 8'h04);
        chk8({7'h00, irq_out_a}, 8'h01);
        wr(8'h23, 8'h40);
        wr(8'h03, 8'h00);
        chk8({7'h00, irq_out_a}, 8'h00);
        report_and_stop();
    end
endmodule
